// File: spc_pkg.sv
package spc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int LPCLK_MHZ = 120;
  localparam int SRST_NS = 200;
  localparam int SRST_CYC = (SRST_NS * CLK_MHZ + 999) / 1000;
  localparam int DET_NS = 1000;
  localparam int DET_CYC = (DET_NS * CLK_MHZ) / 1000;
  localparam int PSTATE_CYC = 4;
  localparam logic [1:0] PWR_P0 = 2'h0;
  localparam logic [1:0] PWR_P1 = 2'h1;
  localparam logic [1:0] PWR_P2 = 2'h2;
  localparam logic [1:0] PWR_P3 = 2'h3;
  localparam logic [2:0] ST_OK = 3'h0;
  localparam logic [2:0] ST_SKP_ADD = 3'h1;
  localparam logic [2:0] ST_SKP_REM = 3'h2;
  localparam logic [2:0] ST_RX_PRESENT = 3'h3;
  localparam logic [2:0] ST_DECODE = 3'h4;
  localparam logic [2:0] ST_OVERFLOW = 3'h5;
  localparam logic [2:0] ST_UNDERFLOW = 3'h6;
  localparam logic [2:0] ST_DISPARITY = 3'h7;
  localparam logic [7:0] SUB_SYM = 8'hFE;
  localparam logic [7:0] SKP_SYM = 8'h3C;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 16;
  typedef enum logic [2:0] {TXM_IDLE, TXM_DATA, TXM_LOOP, TXM_LFPS, TXM_DETECT} spc_txmode_t;
  typedef enum {PS_BOOT, PS_SRST, PS_RUN, PS_CHANGE, PS_DETECT, PS_HOLD} spc_pstate_t;
endpackage : spc_pkg

// File: spc_fifo.sv
`timescale 1ns/1ps
module spc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write valid
  output logic in_ready, // not full
  output logic [WIDTH-1:0] out_data, // head data
  output logic out_valid, // not empty
  input wire logic out_ready, // drain strobe
  output logic [$clog2(DEPTH):0] level // fill count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign level = cnt_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : spc_fifo

// File: spc_phy_ctrl.sv
`timescale 1ns/1ps
module spc_phy_ctrl
  import spc_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int DET_CYCLES = DET_CYC
) (
  input wire logic clk_sys, // 40 MHz core clock
  input wire logic rst, // sync reset, chip reset already synchronised
  input wire logic ce, // freezes all state when low
  input wire logic logic_reset_n, // functional reset, low active
  input wire logic soft_reset_req, // soft reset bit from register set
  input wire logic [1:0] refclk_freq_strap, // strap
  input wire logic [1:0] power_down, // requested power state
  input wire logic tx_detect_or_loopback, // detect / loopback request
  input wire logic tx_electrical_idle, // transmit idle request
  input wire logic rx_term_enable, // receiver termination present
  input wire logic rx_lfps_seen, // analog LFPS detector
  input wire logic rx_far_present, // analog detect comparator
  input wire logic empty_model, // elastic buffer model select
  input wire logic [DW-1:0] rx_sym_data, // decoded symbols
  input wire logic rx_sym_valid, // symbol valid
  input wire logic rx_sym_is_skp, // symbol pair is SKP set
  input wire logic rx_decode_err, // 8b/10b code error
  input wire logic rx_disp_err, // disparity error
  output logic rx_sym_ready, // buffer can take symbols
  output logic [DW-1:0] rx_data, // receive data to controller
  output logic [2:0] rx_event_code, // receive status
  output logic phy_done_pulse, // completion signal
  output logic rx_electrical_idle, // receive idle indication
  output logic low_power_clock_out, // low-power clock enable
  output logic pipe_clk_run, // pipe clock and PLL on
  output logic ulpi_bus_turnaround, // turnaround signal
  output logic rx_cmd_update, // command update pulse
  output logic [2:0] tx_mode, // transmit path selection
  output logic [1:0] strap_refclk // captured strap
);
  localparam int PSW = 8;
  spc_pstate_t ps_q;
  logic [PSW-1:0] cnt_q;
  logic [31:0] det_q;
  logic [1:0] pwr_q;
  logic boot_q;
  logic strap_done_q;
  logic done_q;
  logic [2:0] code_q;
  logic [DW-1:0] data_q;
  logic dir_q;
  logic upd_q;
  logic srst_q;
  logic lpclk_q;
  logic pclk_q;
  logic eidle_q;
  logic [2:0] txm_q;
  logic [DW+2:0] f_out;
  logic f_valid;
  logic f_in_ready;
  logic [$clog2(DEPTH):0] f_level;
  logic under_q;
  logic core_rst;
  logic drain;
  logic det_arm_q;
  // core logic resets on chip or functional reset, not on soft reset
  assign core_rst = rst || !logic_reset_n;

  function automatic logic [2:0] txdecode(input logic [1:0] pw, input logic det, input logic idle);
    logic [2:0] m;
    m = TXM_IDLE;
    if (!idle)
      m = (pw == PWR_P0 && det) ? TXM_LOOP : (pw == PWR_P0) ? TXM_DATA : TXM_LFPS;
    else if (pw == PWR_P0)
      m = det ? TXM_LFPS : TXM_IDLE;
    else if (pw == PWR_P3 || (pw == PWR_P2 && det))
      m = TXM_DETECT;
    return m;
  endfunction : txdecode

  wire [2:0] txm_d = txdecode(pwr_q, tx_detect_or_loopback, tx_electrical_idle);
  wire det_now = (txm_d == TXM_DETECT);
  wire [2:0] present_code = rx_far_present ? ST_RX_PRESENT : ST_OK;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      boot_q <= 1'b1;
      strap_done_q <= 1'b0;
      strap_refclk <= 2'h0;
    end
    else if (ce)
    begin
      boot_q <= 1'b0;
      if (!strap_done_q)
      begin
        strap_refclk <= refclk_freq_strap;
        strap_done_q <= 1'b1;
      end
    end
  end

  // power and detect sequencer
  always_ff @(posedge clk_sys)
  begin
    if (core_rst)
    begin
      ps_q <= PS_BOOT;
      cnt_q <= '0;
      det_q <= '0;
      det_arm_q <= 1'b1;
      pwr_q <= PWR_P2;
      done_q <= 1'b1;
      pclk_q <= 1'b1;
      lpclk_q <= 1'b0;
      srst_q <= 1'b0;
    end
    else if (ce)
    begin
      case (ps_q)
        PS_BOOT:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == PSW'(PSTATE_CYC))
          begin
            done_q <= 1'b0;
            pwr_q <= power_down;
            ps_q <= PS_RUN;
          end
        end
        PS_SRST:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == PSW'(SRST_CYC))
          begin
            srst_q <= 1'b0;
            ps_q <= PS_RUN;
          end
        end
        PS_RUN:
        begin
          done_q <= 1'b0;
          cnt_q <= '0;
          det_q <= '0;
          if (soft_reset_req && !srst_q)
          begin
            srst_q <= 1'b1;
            ps_q <= PS_SRST;
          end
          else if (power_down != pwr_q)
          begin
            pwr_q <= power_down;
            ps_q <= PS_CHANGE;
            pclk_q <= 1'b1;
            lpclk_q <= 1'b0;
          end
          else if (det_now && det_arm_q)
          begin
            det_arm_q <= 1'b0;
            ps_q <= PS_DETECT;
          end
          // a request still held after its result must not start a second detect
          if (!tx_detect_or_loopback && pwr_q != PWR_P3)
            det_arm_q <= 1'b1;
        end
        PS_CHANGE:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (pwr_q == PWR_P3)
          begin
            if (cnt_q == PSW'(PSTATE_CYC))
              done_q <= 1'b1;
            if (cnt_q == PSW'(PSTATE_CYC + 1))
              pclk_q <= 1'b0;
            if (cnt_q == PSW'(PSTATE_CYC + 2))
            begin
              done_q <= 1'b0;
              lpclk_q <= 1'b1;
              det_arm_q <= 1'b1;
              ps_q <= PS_RUN;
            end
          end
          else if (cnt_q == PSW'(PSTATE_CYC))
          begin
            done_q <= 1'b1;
            det_arm_q <= 1'b1;
            ps_q <= PS_RUN;
          end
        end
        PS_DETECT:
        begin
          det_q <= det_q + 1'b1;
          if (det_q == 32'(DET_CYCLES))
          begin
            done_q <= 1'b1;
            ps_q <= (pwr_q == PWR_P3) ? PS_HOLD : PS_RUN;
          end
        end
        PS_HOLD:
        begin
          if (!tx_detect_or_loopback)
          begin
            done_q <= 1'b0;
            ps_q <= PS_RUN;
          end
        end
        default:
          ps_q <= PS_BOOT;
      endcase
    end
  end

  // turnaround and command update around soft reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dir_q <= 1'b1;
      upd_q <= 1'b0;
    end
    else if (ce)
    begin
      dir_q <= !srst_q;
      upd_q <= !dir_q && !srst_q;
    end
  end

  // monitoring stays on in all power states
  always_ff @(posedge clk_sys)
  begin
    if (core_rst)
    begin
      eidle_q <= 1'b1;
      txm_q <= TXM_IDLE;
    end
    else if (ce)
    begin
      eidle_q <= !(rx_lfps_seen && rx_term_enable);
      txm_q <= (ps_q == PS_RUN || ps_q == PS_DETECT) ? txm_d : TXM_IDLE;
    end
  end

  // elastic buffer: decode/disparity flags travel with the data
  spc_fifo #(
    .WIDTH(DW + 3),
    .DEPTH(DEPTH)
  ) u_eb (
    .clk_sys(clk_sys),
    .rst(core_rst),
    .ce(ce),
    .in_data({rx_sym_is_skp, rx_decode_err, rx_disp_err, rx_sym_data}),
    .in_valid(rx_sym_valid),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_valid),
    .out_ready(drain),
    .level(f_level)
  );
  // overflow: symbol arrives while full, so it is dropped
  wire ovf = rx_sym_valid && !f_in_ready;
  wire half = f_level >= ($clog2(DEPTH)+1)'(DEPTH / 2);
  wire head_skp = f_valid && f_out[DW+2];
  // half-full model flags ST_SKP_REM on a SKP set at or above half but still forwards it to rx_data, adds one when below
  wire skp_rem = !empty_model && head_skp && half;
  wire skp_add = !empty_model && head_skp && !half && !under_q;
  assign drain = !skp_add;
  wire under = !f_valid && !empty_model;
  // status priority: decode, overflow, underflow, disparity, SKP, detect
  wire [2:0] st_d =
    (f_valid && f_out[DW+1]) ? ST_DECODE :
    ovf ? ST_OVERFLOW :
    under ? ST_UNDERFLOW :
    (f_valid && f_out[DW]) ? ST_DISPARITY :
    skp_add ? ST_SKP_ADD :
    skp_rem ? ST_SKP_REM :
    (ps_q == PS_DETECT && det_q == 32'(DET_CYCLES)) ? present_code :
    ps_q == PS_HOLD ? code_q : ST_OK;
  // empty model inserts SKP instead of flagging underflow
  wire [DW-1:0] dat_d =
    (f_valid && f_out[DW+1]) ? {SUB_SYM, f_out[7:0]} :
    f_valid ? f_out[DW-1:0] :
    empty_model ? {SKP_SYM, SKP_SYM} : {SUB_SYM, SUB_SYM};

  always_ff @(posedge clk_sys)
  begin
    if (core_rst)
    begin
      code_q <= ST_OK;
      data_q <= '0;
      under_q <= 1'b0;
    end
    else if (ce)
    begin
      code_q <= st_d;
      data_q <= dat_d;
      under_q <= under;
    end
  end

  assign rx_sym_ready = f_in_ready;
  assign rx_data = data_q;
  assign rx_event_code = code_q;
  assign phy_done_pulse = done_q;
  assign rx_electrical_idle = eidle_q;
  assign low_power_clock_out = lpclk_q;
  assign pipe_clk_run = pclk_q;
  assign ulpi_bus_turnaround = dir_q;
  assign rx_cmd_update = upd_q;
  assign tx_mode = txm_q;

  a_lpclk_p3: assert property (@(posedge clk_sys) disable iff (rst)
    low_power_clock_out |-> pwr_q == PWR_P3) else $error("low-power clock outside P3");
  a_p0_pulse: assert property (@(posedge clk_sys) disable iff (core_rst)
    (ps_q == PS_CHANGE && pwr_q != PWR_P3 && $rose(done_q)) |=> !done_q) else $error("done not single");
  a_p3_order: assert property (@(posedge clk_sys) disable iff (core_rst)
    ($fell(pipe_clk_run) && ce) |-> done_q) else $error("clock stopped without done");
  a_idle_lfps: assert property (@(posedge clk_sys) disable iff (core_rst)
    ($fell(eidle_q)) |-> $past(rx_term_enable)) else $error("idle drop without termination");
  a_decode_sub: assert property (@(posedge clk_sys) disable iff (core_rst)
    (rx_event_code == ST_DECODE) |-> rx_data[DW-1 -: 8] == SUB_SYM) else $error("decode without SUB");
  a_under_sub: assert property (@(posedge clk_sys) disable iff (core_rst)
    (rx_event_code == ST_UNDERFLOW) |-> rx_data == {SUB_SYM, SUB_SYM}) else $error("underflow without SUB");
  a_empty_noflag: assert property (@(posedge clk_sys) disable iff (core_rst)
    (ce && $past(empty_model)) |-> rx_event_code != ST_UNDERFLOW) else $error("underflow in empty model");
  a_turn_back: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && $rose(ulpi_bus_turnaround)) |-> rx_cmd_update)
    else $error("no command update");
endmodule : spc_phy_ctrl

// File: spc_link_model.sv
`timescale 1ns/1ps
module spc_link_model
  import spc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst, // sync reset
  input wire logic phy_done_pulse, // device completion
  input wire logic go, // apply the wanted levels
  input wire logic [1:0] want_pd, // wanted power state
  input wire logic want_det, // wanted detect or loopback
  input wire logic want_idle, // wanted transmit idle
  output logic [1:0] power_down, // to device
  output logic tx_detect_or_loopback, // to device
  output logic tx_electrical_idle, // to device
  output logic busy // waiting on completion
);
  logic wait_d;
  // a state change or a detect in P2/P3 must see completion before anything else
  assign wait_d = (want_pd != power_down) || (want_det && !tx_detect_or_loopback && want_idle && want_pd[1]);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      power_down <= PWR_P2;
      tx_detect_or_loopback <= 1'b0;
      tx_electrical_idle <= 1'b1;
      busy <= 1'b0;
    end
    else if (go && !busy)
    begin
      power_down <= want_pd;
      tx_detect_or_loopback <= want_det;
      tx_electrical_idle <= want_idle || (want_pd == PWR_P0 && power_down != PWR_P0);
      busy <= wait_d;
    end
    else if (phy_done_pulse)
      busy <= 1'b0;
  end
endmodule : spc_link_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top
  import spc_pkg::*;
;
  logic clk_sys, rst, soft_reset_req, rx_term_enable, rx_lfps_seen, rx_far_present, empty_model;
  logic rx_sym_valid, rx_decode_err, rx_disp_err, go, want_det, want_idle, busy;
  logic [1:0] refclk_freq_strap, want_pd, power_down, strap_refclk;
  logic tx_detect_or_loopback, tx_electrical_idle, rx_sym_ready, phy_done_pulse, rx_electrical_idle;
  logic low_power_clock_out, pipe_clk_run, ulpi_bus_turnaround, rx_cmd_update;
  logic [15:0] rx_sym_data, rx_data;
  logic [2:0] rx_event_code, tx_mode;
  int fails = 0;
  int checked = 0;
  int cyc = 0;

  spc_phy_ctrl #(.DET_CYCLES(5)) i_spc_phy_ctrl (
    .clk_sys, .rst, .ce(1'b1), .logic_reset_n(1'b1), .soft_reset_req, .refclk_freq_strap,
    .power_down, .tx_detect_or_loopback, .tx_electrical_idle, .rx_term_enable, .rx_lfps_seen,
    .rx_far_present, .empty_model, .rx_sym_data, .rx_sym_valid, .rx_sym_is_skp(1'b0),
    .rx_decode_err, .rx_disp_err, .rx_sym_ready, .rx_data, .rx_event_code, .phy_done_pulse,
    .rx_electrical_idle, .low_power_clock_out, .pipe_clk_run, .ulpi_bus_turnaround,
    .rx_cmd_update, .tx_mode, .strap_refclk
  );

  spc_link_model i_spc_link_model (
    .clk_sys, .rst, .phy_done_pulse, .go, .want_pd, .want_det, .want_idle,
    .power_down, .tx_detect_or_loopback, .tx_electrical_idle, .busy
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic final_report;
    $display("counts checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bounded wait on one output, judged at the falling edge
  task automatic wait_sel(input int s, input logic v, input int n, input string nm);
    logic got;
    got = ~v;
    for (int i = 0; i < n && got !== v; i++)
    begin
      @(negedge clk_sys);
      case (s)
        0: got = phy_done_pulse;
        1: got = pipe_clk_run;
        2: got = ulpi_bus_turnaround;
        3: got = rx_cmd_update;
        4: got = rx_electrical_idle;
        default: got = low_power_clock_out;
      endcase
    end
    chk(nm, 16'(v), 16'(got));
  endtask : wait_sel

  task automatic req(input logic [1:0] pd, input logic d, input logic idl);
    @(posedge clk_sys);
    want_pd <= pd;
    want_det <= d;
    want_idle <= idl;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask : req

  task automatic t_reset;
    wait_sel(0, 1'b0, 12, "done_fall");
    chk("strap", 16'h0001, 16'(strap_refclk));
    chk("status_idle", 16'(ST_OK), 16'(rx_event_code));
    chk("lpclk_off", 16'h0000, 16'(low_power_clock_out));
    chk("sym_ready", 16'h0001, 16'(rx_sym_ready));
    $display("test reset done");
  endtask : t_reset

  task automatic t_pwr(input logic [1:0] pd);
    req(pd, 1'b0, 1'b1);
    wait_sel(0, 1'b1, 12, "done_rise");
    if (pd != PWR_P3)
    begin
      @(negedge clk_sys);
      chk("done_single", 16'h0000, 16'(phy_done_pulse));
      chk("pclk_on", 16'h0001, 16'(pipe_clk_run));
      wait_sel(5, 1'b0, 4, "lpclk_off");
    end
    else
    begin
      wait_sel(1, 1'b0, 4, "pclk_stop");
      wait_sel(0, 1'b0, 4, "done_drop");
      wait_sel(5, 1'b1, 4, "lpclk_on");
      wait_sel(0, 1'b1, 12, "p3_det_done");
      chk("p3_det_code", 16'(ST_OK), 16'(rx_event_code));
      wait_sel(0, 1'b0, 4, "p3_det_drop");
    end
    $display("test power %0d done", pd);
  endtask : t_pwr

  task automatic t_lfps;
    req(PWR_P1, 1'b0, 1'b0);
    repeat (3) @(negedge clk_sys);
    chk("p1_lfps", 16'h0003, 16'(tx_mode));
    req(PWR_P1, 1'b1, 1'b1);
    repeat (3) @(negedge clk_sys);
    chk("p1_idle", 16'h0000, 16'(tx_mode));
    req(PWR_P1, 1'b0, 1'b1);
    $display("test lfps done");
  endtask : t_lfps

  task automatic t_txmode;
    logic [2:0] ex [4] = '{3'h1, 3'h0, 3'h2, 3'h3};
    for (int i = 0; i < 4; i++)
    begin
      req(PWR_P0, i[1], i[0]);
      repeat (3) @(negedge clk_sys);
      chk("p0_mode", 16'(ex[i]), 16'(tx_mode));
    end
    req(PWR_P0, 1'b0, 1'b1);
    $display("test tx matrix done");
  endtask : t_txmode

  task automatic t_detect;
    for (int i = 1; i >= 0; i--)
    begin
      @(posedge clk_sys);
      rx_far_present <= i[0];
      req(PWR_P2, 1'b1, 1'b1);
      wait_sel(0, 1'b1, 20, "det_done");
      chk("det_code", 16'(i[0] ? ST_RX_PRESENT : ST_OK), 16'(rx_event_code));
      @(negedge clk_sys);
      chk("det_single", 16'h0000, 16'(phy_done_pulse));
      req(PWR_P2, 1'b0, 1'b1);
    end
    $display("test detect done");
  endtask : t_detect

  task automatic t_sym(input logic [15:0] d, input logic de, input logic di, input logic [2:0] ec,
                       input logic [15:0] ed);
    @(posedge clk_sys);
    rx_sym_data <= d;
    rx_sym_valid <= 1'b1;
    rx_decode_err <= de;
    rx_disp_err <= di;
    @(posedge clk_sys);
    rx_sym_valid <= 1'b0;
    rx_decode_err <= 1'b0;
    rx_disp_err <= 1'b0;
    // key on the data word so fill cycles around it are not mistaken for it
    for (int i = 0; i < 30 && rx_data !== ed; i++)
      @(negedge clk_sys);
    chk("rx_data", ed, rx_data);
    chk("rx_code", 16'(ec), 16'(rx_event_code));
    $display("test symbol %h done", d);
  endtask : t_sym

  task automatic t_under;
    @(posedge clk_sys);
    empty_model <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("under_code", 16'(ST_UNDERFLOW), 16'(rx_event_code));
    chk("under_data", {SUB_SYM, SUB_SYM}, rx_data);
    @(posedge clk_sys);
    empty_model <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("empty_code", 16'(ST_OK), 16'(rx_event_code));
    $display("test underflow done");
  endtask : t_under

  task automatic t_rxidle;
    @(posedge clk_sys);
    rx_lfps_seen <= 1'b1;
    wait_sel(4, 1'b0, 6, "rx_idle_low");
    @(posedge clk_sys);
    rx_term_enable <= 1'b0;
    wait_sel(4, 1'b1, 6, "rx_idle_unterm");
    @(posedge clk_sys);
    rx_lfps_seen <= 1'b0;
    rx_term_enable <= 1'b1;
    $display("test rx idle done");
  endtask : t_rxidle

  task automatic t_srst;
    @(posedge clk_sys);
    soft_reset_req <= 1'b1;
    wait_sel(2, 1'b0, 6, "turn_low");
    @(posedge clk_sys);
    soft_reset_req <= 1'b0;
    wait_sel(2, 1'b1, SRST_CYC + 12, "turn_back");
    chk("cmd_update", 16'h0001, 16'(rx_cmd_update));
    chk("strap_kept", 16'h0001, 16'(strap_refclk));
    $display("test soft reset done");
  endtask : t_srst

  initial
  begin
    rst = 1'b1;
    go = 1'b0;
    want_pd = PWR_P2;
    want_det = 1'b0;
    want_idle = 1'b1;
    soft_reset_req = 1'b0;
    refclk_freq_strap = 2'h1;
    rx_term_enable = 1'b1;
    rx_lfps_seen = 1'b0;
    rx_far_present = 1'b0;
    empty_model = 1'b1;
    rx_sym_data = 16'h0000;
    rx_sym_valid = 1'b0;
    rx_decode_err = 1'b0;
    rx_disp_err = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // a late strap change must not reach the captured copy
    repeat (3) @(posedge clk_sys);
    refclk_freq_strap <= 2'h2;
    t_reset();
    t_pwr(PWR_P1);
    t_lfps();
    t_pwr(PWR_P0);
    t_txmode();
    t_pwr(PWR_P2);
    t_detect();
    t_pwr(PWR_P3);
    t_pwr(PWR_P2);
    t_sym(16'h1234, 1'b1, 1'b1, ST_DECODE, {SUB_SYM, 8'h34});
    t_sym(16'h5678, 1'b0, 1'b1, ST_DISPARITY, 16'h5678);
    t_sym(16'hA5C3, 1'b0, 1'b0, ST_OK, 16'hA5C3);
    t_under();
    t_rxidle();
    t_srst();
    final_report();
  end
endmodule : tb_top
